// File: rtl/cri_defines.svh
`ifndef CRI_DEFINES_SVH
`define CRI_DEFINES_SVH

// reset pin must be seen low this many clocks in a row
`define CRI_RESET_MIN_CLKS 2'h3
`define CRI_RESET_CNT_ZERO 2'h0
`define CRI_RESET_CNT_STEP 2'h1

// fixed service entry addresses
`define CRI_NMI_ADDR 16'h0066
`define CRI_RST38_ADDR 16'h0038
`define CRI_ADDR_ZERO 16'h0000

// synchroniser lanes (all pins idle high)
`define CRI_PIN_W 4
`define CRI_PIN_IDLE 4'hF
`define CRI_PIN_RESET 3
`define CRI_PIN_NMI 2
`define CRI_PIN_INT 1
`define CRI_PIN_HOLD 0

// reset value of the initialised registers, and the refresh counter step
`define CRI_BYTE_ZERO 8'h00
`define CRI_REFRESH_STEP 7'h01

`endif

// File: rtl/cri_pkg.sv
package cri_pkg;

    // maskable interrupt modes
    typedef enum logic [1:0] {
        CRI_IM0 = 2'h0,
        CRI_IM1 = 2'h1,
        CRI_IM2 = 2'h2
    } cri_im_t;

    // acknowledge cycle, gray coded along the path
    typedef enum logic [2:0] {
        CRI_ACK_IDLE = 3'h0,
        CRI_ACK_T1 = 3'h1,
        CRI_ACK_T2 = 3'h3,
        CRI_ACK_TW1 = 3'h2,
        CRI_ACK_TW2 = 3'h6,
        CRI_ACK_T3 = 3'h7
    } cri_ack_t;

endpackage

// File: rtl/cri_sync_if.sv
`timescale 1ns/1ps
`default_nettype none

// raw pin levels in, synchronised levels out
interface cri_sync_if #(parameter int W = 1);
    logic [W-1:0] raw;
    logic [W-1:0] sync;
    modport sync_side (input raw, output sync);
    modport user (output raw, input sync);
endinterface

`default_nettype wire

// File: rtl/cri_sync.sv
`timescale 1ns/1ps
`default_nettype none
`include "cri_defines.svh"

// two-stage synchroniser; first stage feeds only the second
module cri_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] IDLE = '1
) (
    input wire logic clk,
    input wire logic rst_n,
    cri_sync_if.sync_side pins
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    // idle level under reset so no false edge is seen on release
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_ff <= IDLE;
            sync_ff <= IDLE;
        end else begin
            meta_ff <= pins.raw;
            sync_ff <= meta_ff;
        end
    end

    assign pins.sync = sync_ff;
endmodule

`default_nettype wire

// File: rtl/cri_exc_ctrl.sv
// Summary of operation
// - while the bus is away, no refresh strobe and address floats.
// - no interrupt is accepted while the bus is granted away.
// - reset clears pc, enable, nmi latch, vector page, refresh, and also sets mode 0.
// - maskable interrupt mode 0 is in effect after reset.
// - the enable instruction sets the enable flag only one later.
// - interrupt entry saves only the program counter.
// - mode 2 builds a table address from vector page and device byte.
// - the acknowledge cycle carries two automatic wait states.
// - an accepted maskable request also leaves the halt state.
`timescale 1ns/1ps
`default_nettype none
`include "cri_defines.svh"

module cri_exc_ctrl
    import cri_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic RESET_PIN_N,
    input wire logic NMI_N,
    input wire logic INT_N,
    input wire logic BUS_HOLD_REQUEST_N,
    input wire logic M_CYCLE_END,
    input wire logic INSTR_END,
    input wire logic IRQ_ENABLE_INSTRUCTION,
    input wire logic IRQ_DISABLE_INSTRUCTION,
    input wire logic IRQ_RETURN_NMI,
    input wire logic IM_SET,
    input wire logic [1:0] IM_VALUE,
    input wire logic HALT_ENTER,
    input wire logic VECTOR_PAGE_LOAD,
    input wire logic REFRESH_LOAD,
    input wire logic [7:0] LOAD_DATA,
    input wire logic REFRESH_SLOT,
    input wire logic [7:0] ACK_DATA,
    output logic CORE_RESET,
    output logic BUS_HOLD_GRANT_N,
    output logic DRAM_REFRESH_STROBE_N,
    output logic ADDR_OE,
    output logic DATA_OE,
    output logic CTRL_OE,
    output logic INTA_CYCLE,
    output logic AUTO_WAIT_STATE,
    output logic PUSH_PC,
    output logic SERVICE_VALID,
    output logic [15:0] SERVICE_ADDR,
    output logic SERVICE_OPCODE_VALID,
    output logic [7:0] SERVICE_OPCODE,
    output logic HALT_N,
    output logic IRQ_ENABLED,
    output logic [1:0] INT_MODE,
    output logic [7:0] VECTOR_PAGE,
    output logic [7:0] REFRESH_ADDR
);
    //------------------------------------------------------------------
    // pin synchronisers
    //------------------------------------------------------------------
    cri_sync_if #(.W(`CRI_PIN_W)) pin_if ();
    assign pin_if.raw = {RESET_PIN_N, NMI_N, INT_N, BUS_HOLD_REQUEST_N};

    cri_sync #(.W(`CRI_PIN_W), .IDLE(`CRI_PIN_IDLE)) u_sync (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .pins(pin_if.sync_side)
    );

    logic rst_pin_n_s;
    logic nmi_n_s;
    logic int_n_s;
    logic hold_n_s;
    assign rst_pin_n_s = pin_if.sync[`CRI_PIN_RESET];
    assign nmi_n_s = pin_if.sync[`CRI_PIN_NMI];
    assign int_n_s = pin_if.sync[`CRI_PIN_INT];
    assign hold_n_s = pin_if.sync[`CRI_PIN_HOLD];

    //------------------------------------------------------------------
    // reset qualification
    //------------------------------------------------------------------
    logic [1:0] low_cnt_ff;
    logic [1:0] nxt_low_cnt;
    logic core_reset_ff;
    logic in_reset;

    // glitches shorter than the minimum never reach the core
    always_comb begin
        if (rst_pin_n_s)
            nxt_low_cnt = `CRI_RESET_CNT_ZERO;
        else if (low_cnt_ff == `CRI_RESET_MIN_CLKS)
            nxt_low_cnt = low_cnt_ff;
        else
            nxt_low_cnt = low_cnt_ff + `CRI_RESET_CNT_STEP;
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            low_cnt_ff <= `CRI_RESET_CNT_ZERO;
            core_reset_ff <= 1'b1;
        end else begin
            low_cnt_ff <= nxt_low_cnt;
            core_reset_ff <= (nxt_low_cnt == `CRI_RESET_MIN_CLKS);
        end
    end

    assign in_reset = !RST_N || core_reset_ff;
    assign CORE_RESET = core_reset_ff; // core clears its program counter

    //------------------------------------------------------------------
    // bus hold and acceptance window
    //------------------------------------------------------------------
    cri_ack_t ack_st_ff;
    cri_ack_t nxt_ack_st;
    logic grant_ff;
    logic grant_take;
    logic boundary;
    logic nmi_pend_ff;
    logic nmi_prev_ff;
    logic iff1_ff;
    logic iff2_ff;
    logic ei_pend_ff;
    logic take_nmi;
    logic take_int;

    assign grant_take = !grant_ff && M_CYCLE_END && !hold_n_s &&
                        (ack_st_ff == CRI_ACK_IDLE);

    // nothing taken while the bus is away
    assign boundary = INSTR_END && !grant_ff && !grant_take &&
                      (ack_st_ff == CRI_ACK_IDLE);
    assign take_nmi = boundary && nmi_pend_ff;
    assign take_int = boundary && !nmi_pend_ff && !int_n_s &&
                      iff1_ff && !ei_pend_ff;

    always_ff @(posedge CLK_SYS) begin
        if (in_reset)
            grant_ff <= 1'b0;
        else if (grant_ff)
            grant_ff <= !hold_n_s;
        else
            grant_ff <= grant_take;
    end

    assign ADDR_OE = !grant_ff;
    assign DATA_OE = !grant_ff;
    assign CTRL_OE = !grant_ff;
    assign BUS_HOLD_GRANT_N = !grant_ff;

    //------------------------------------------------------------------
    // nmi edge latch
    //------------------------------------------------------------------
    // falling edge caught any time, served at a boundary
    always_ff @(posedge CLK_SYS) begin
        if (in_reset) begin
            nmi_prev_ff <= 1'b1;
            nmi_pend_ff <= 1'b0;
        end else begin
            nmi_prev_ff <= nmi_n_s;
            // a new edge wins over the clear by acceptance
            nmi_pend_ff <= (nmi_prev_ff && !nmi_n_s) ||
                           (nmi_pend_ff && !take_nmi);
        end
    end

    //------------------------------------------------------------------
    // interrupt enable flags and mode
    //------------------------------------------------------------------
    // enable flags with one-instruction delay
    always_ff @(posedge CLK_SYS) begin
        if (in_reset) begin
            iff1_ff <= 1'b0;
            iff2_ff <= 1'b0;
            ei_pend_ff <= 1'b0;
        end else if (take_nmi) begin
            iff2_ff <= iff1_ff; // kept so the nmi return can restore it
            iff1_ff <= 1'b0;
        end else if (take_int) begin
            iff1_ff <= 1'b0;
            iff2_ff <= 1'b0;
        end else if (IRQ_DISABLE_INSTRUCTION) begin
            iff1_ff <= 1'b0;
            iff2_ff <= 1'b0;
            ei_pend_ff <= 1'b0;
        end else if (INSTR_END && ei_pend_ff) begin
            iff1_ff <= 1'b1;
            iff2_ff <= 1'b1;
            ei_pend_ff <= IRQ_ENABLE_INSTRUCTION;
        end else if (IRQ_ENABLE_INSTRUCTION) begin
            ei_pend_ff <= 1'b1;
        end else if (IRQ_RETURN_NMI) begin
            iff1_ff <= iff2_ff;
        end
    end

    cri_im_t im_ff;

    always_ff @(posedge CLK_SYS) begin
        if (in_reset)
            im_ff <= CRI_IM0;
        else if (IM_SET)
            im_ff <= cri_im_t'(IM_VALUE);
    end

    assign INT_MODE = im_ff;
    assign IRQ_ENABLED = iff1_ff;

    //------------------------------------------------------------------
    // vector page, refresh counter and strobe
    //------------------------------------------------------------------
    logic [7:0] vec_page_ff;
    logic [7:0] refresh_ff;
    logic strobe_n_ff;
    logic refresh_ok;

    // refresh is suppressed the cycle the grant is taken, too
    assign refresh_ok = REFRESH_SLOT && !grant_ff && !grant_take;

    // vector page and refresh counter cleared
    always_ff @(posedge CLK_SYS) begin
        if (in_reset) begin
            vec_page_ff <= `CRI_BYTE_ZERO;
            refresh_ff <= `CRI_BYTE_ZERO;
        end else begin
            if (VECTOR_PAGE_LOAD)
                vec_page_ff <= LOAD_DATA;
            // top bit is only ever loaded, low seven bits wrap
            if (REFRESH_LOAD)
                refresh_ff <= LOAD_DATA;
            else if (refresh_ok)
                refresh_ff <= {refresh_ff[7],
                               refresh_ff[6:0] + `CRI_REFRESH_STEP};
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (in_reset)
            strobe_n_ff <= 1'b1;
        else
            strobe_n_ff <= !refresh_ok;
    end

    assign DRAM_REFRESH_STROBE_N = strobe_n_ff;
    assign VECTOR_PAGE = vec_page_ff;
    assign REFRESH_ADDR = refresh_ff;

    //------------------------------------------------------------------
    // acknowledge cycle
    //------------------------------------------------------------------
    // two automatic waits between T2 and T3
    always_comb begin
        case (ack_st_ff)
            CRI_ACK_IDLE: nxt_ack_st = take_int ? CRI_ACK_T1 : CRI_ACK_IDLE;
            CRI_ACK_T1: nxt_ack_st = CRI_ACK_T2;
            CRI_ACK_T2: nxt_ack_st = CRI_ACK_TW1;
            CRI_ACK_TW1: nxt_ack_st = CRI_ACK_TW2;
            CRI_ACK_TW2: nxt_ack_st = CRI_ACK_T3;
            CRI_ACK_T3: nxt_ack_st = CRI_ACK_IDLE;
            default: nxt_ack_st = CRI_ACK_IDLE;
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (in_reset)
            ack_st_ff <= CRI_ACK_IDLE;
        else
            ack_st_ff <= nxt_ack_st;
    end

    assign INTA_CYCLE = (ack_st_ff != CRI_ACK_IDLE);
    assign AUTO_WAIT_STATE = (ack_st_ff == CRI_ACK_TW1) ||
                             (ack_st_ff == CRI_ACK_TW2);

    //------------------------------------------------------------------
    // service dispatch
    //------------------------------------------------------------------
    logic [15:0] mode2_addr;
    logic svc_valid_ff;
    logic push_ff;
    logic op_valid_ff;
    logic [15:0] svc_addr_ff;
    logic [7:0] op_ff;
    logic ack_end;

    // table entry from page and even peripheral byte
    assign mode2_addr = {vec_page_ff, ACK_DATA[7:1], 1'b0};
    assign ack_end = (ack_st_ff == CRI_ACK_T3);

    // only the program counter is pushed
    always_ff @(posedge CLK_SYS) begin
        if (in_reset) begin
            svc_valid_ff <= 1'b0;
            push_ff <= 1'b0;
            op_valid_ff <= 1'b0;
            svc_addr_ff <= `CRI_ADDR_ZERO;
            op_ff <= `CRI_BYTE_ZERO;
        end else begin
            svc_valid_ff <= take_nmi || ack_end;
            // mode 0 opcode does its own push if it is a restart
            push_ff <= take_nmi || (ack_end && im_ff != CRI_IM0);
            op_valid_ff <= ack_end && im_ff == CRI_IM0;
            if (take_nmi)
                svc_addr_ff <= `CRI_NMI_ADDR;
            else if (ack_end && im_ff == CRI_IM2)
                svc_addr_ff <= mode2_addr;
            else if (ack_end && im_ff == CRI_IM1)
                svc_addr_ff <= `CRI_RST38_ADDR;
            else if (ack_end)
                svc_addr_ff <= `CRI_ADDR_ZERO;
            if (ack_end)
                op_ff <= ACK_DATA;
        end
    end

    assign SERVICE_VALID = svc_valid_ff;
    assign PUSH_PC = push_ff;
    assign SERVICE_OPCODE_VALID = op_valid_ff;
    assign SERVICE_ADDR = svc_addr_ff;
    assign SERVICE_OPCODE = op_ff;

    //------------------------------------------------------------------
    // halt
    //------------------------------------------------------------------
    logic halted_ff;

    always_ff @(posedge CLK_SYS) begin
        if (in_reset)
            halted_ff <= 1'b0;
        else if (take_int || take_nmi)
            halted_ff <= 1'b0;
        else if (HALT_ENTER)
            halted_ff <= 1'b1;
    end

    assign HALT_N = !halted_ff;

    //------------------------------------------------------------------
    // assertions
    //------------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (in_reset);

    a_refresh_hold_idle: assert property (
        grant_ff |-> DRAM_REFRESH_STROBE_N && !ADDR_OE && !CTRL_OE)
        else $error("refresh or drive while bus granted");
    a_no_irq_granted: assert property (
        grant_ff |=> $stable(ack_st_ff) && !SERVICE_VALID)
        else $error("interrupt taken while bus granted");
    a_reset_init_regs: assert property (disable iff (!RST_N)
        core_reset_ff |=> !iff1_ff && !nmi_pend_ff &&
        vec_page_ff == `CRI_BYTE_ZERO && refresh_ff == `CRI_BYTE_ZERO)
        else $error("reset left a register set");
    a_mode_zero_reset: assert property (disable iff (!RST_N)
        core_reset_ff ##1 !core_reset_ff |-> INT_MODE == CRI_IM0)
        else $error("mode not zero after reset");
    a_ei_delay_one: assert property (
        IRQ_ENABLE_INSTRUCTION && !iff1_ff && !ei_pend_ff |=> !iff1_ff)
        else $error("enable took effect at once");
    a_nmi_push_pc: assert property (
        take_nmi |=> PUSH_PC && SERVICE_VALID &&
        SERVICE_ADDR == `CRI_NMI_ADDR && !SERVICE_OPCODE_VALID)
        else $error("nmi entry wrong");
    a_mode2_vector: assert property (
        ack_end && im_ff == CRI_IM2 |=> SERVICE_VALID &&
        SERVICE_ADDR == $past(mode2_addr))
        else $error("mode 2 table address wrong");
    a_two_waits: assert property (
        take_int |=> INTA_CYCLE ##1 !AUTO_WAIT_STATE ##1
        AUTO_WAIT_STATE [*2] ##1 !AUTO_WAIT_STATE ##1 SERVICE_VALID)
        else $error("acknowledge wait count wrong");
    a_halt_release: assert property (
        halted_ff && take_int |=> HALT_N)
        else $error("halt not left on interrupt");
    a_grant_at_end: assert property (
        $rose(grant_ff) |-> $past(M_CYCLE_END) && $past(!hold_n_s))
        else $error("grant outside cycle end");
endmodule

`default_nettype wire

// File: tb/cri_far_side.sv
`timescale 1ns/1ps
`default_nettype none

// far side: interrupt sources, acknowledging peripheral, other master
module cri_far_side (
    input wire logic clk,
    input wire logic int_req,
    input wire logic nmi_req,
    input wire logic hold_req,
    input wire logic [7:0] ack_val,
    input wire logic inta,
    output logic int_n,
    output logic nmi_n,
    output logic hold_n,
    output logic [7:0] ack_data
);
    logic [7:0] junk_ff;
    // pins idle high from time zero
    initial begin
        int_n = 1'b1;
        nmi_n = 1'b1;
        hold_n = 1'b1;
        junk_ff = 8'h5A;
    end
    // requests move just after the edge, one clock behind the request inputs
    always @(posedge clk) begin
        int_n <= ~int_req;
        nmi_n <= ~nmi_req;
        hold_n <= ~hold_req;
        junk_ff <= ~junk_ff;
    end
    // released bus shows a toggling pattern, never a stale byte
    assign ack_data = inta ? ack_val : junk_ff;
endmodule

`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import cri_pkg::*;
    logic CLK_SYS = 0, RST_N = 0, RESET_PIN_N = 1, M_CYCLE_END = 0;
    logic INSTR_END = 0, IRQ_ENABLE_INSTRUCTION = 0, IM_SET = 0;
    logic IRQ_DISABLE_INSTRUCTION = 0, IRQ_RETURN_NMI = 0;
    logic HALT_ENTER = 0, VECTOR_PAGE_LOAD = 0, REFRESH_LOAD = 0;
    logic REFRESH_SLOT = 0, p_int = 0, p_nmi = 0, p_hold = 0;
    logic [1:0] IM_VALUE = 0;
    logic [7:0] LOAD_DATA = 0, p_ack = 0, a, pg;
    wire logic NMI_N, INT_N, BUS_HOLD_REQUEST_N;
    wire logic CORE_RESET, BUS_HOLD_GRANT_N, DRAM_REFRESH_STROBE_N;
    wire logic ADDR_OE, DATA_OE, CTRL_OE, INTA_CYCLE, AUTO_WAIT_STATE;
    wire logic PUSH_PC, SERVICE_VALID, SERVICE_OPCODE_VALID, HALT_N;
    wire logic IRQ_ENABLED;
    wire logic [15:0] SERVICE_ADDR;
    wire logic [7:0] ACK_DATA, SERVICE_OPCODE, VECTOR_PAGE, REFRESH_ADDR;
    wire logic [1:0] INT_MODE;
    int error_cnt = 0, checked = 0, ni, nw;
    logic cs, sl;
    logic [25:0] expq[$];

    cri_exc_ctrl u_cri_exc_ctrl (.CLK_SYS, .RST_N, .RESET_PIN_N, .NMI_N,
        .INT_N, .BUS_HOLD_REQUEST_N, .M_CYCLE_END, .INSTR_END,
        .IRQ_ENABLE_INSTRUCTION, .IRQ_DISABLE_INSTRUCTION,
        .IRQ_RETURN_NMI, .IM_SET, .IM_VALUE, .HALT_ENTER,
        .VECTOR_PAGE_LOAD, .REFRESH_LOAD, .LOAD_DATA, .REFRESH_SLOT,
        .ACK_DATA, .CORE_RESET, .BUS_HOLD_GRANT_N, .DRAM_REFRESH_STROBE_N,
        .ADDR_OE, .DATA_OE, .CTRL_OE, .INTA_CYCLE, .AUTO_WAIT_STATE,
        .PUSH_PC, .SERVICE_VALID, .SERVICE_ADDR, .SERVICE_OPCODE_VALID,
        .SERVICE_OPCODE, .HALT_N, .IRQ_ENABLED, .INT_MODE, .VECTOR_PAGE,
        .REFRESH_ADDR);

    cri_far_side u_cri_far_side (.clk(CLK_SYS), .int_req(p_int),
        .nmi_req(p_nmi), .hold_req(p_hold), .ack_val(p_ack),
        .inta(INTA_CYCLE), .int_n(INT_N), .nmi_n(NMI_N),
        .hold_n(BUS_HOLD_REQUEST_N), .ack_data(ACK_DATA));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    always #5 CLK_SYS = ~CLK_SYS;

    task automatic results();
        if (error_cnt == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t value %h expected %h", $time, got, exp);
        end
    endtask

    // opcode only matters when the opcode flag is expected
    task automatic chk_svc(input logic [25:0] got, input logic [25:0] exp);
        checked++;
        if (exp[8] !== 1'b1) got[7:0] = exp[7:0];
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t service %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge CLK_SYS);
    endtask

    // sample settled outputs for n cycles, ends on an edge
    task automatic obs(input int n);
        ni = 0;
        nw = 0;
        cs = 0;
        sl = 0;
        repeat (n) begin
            #1;
            ni += (INTA_CYCLE === 1'b1);
            nw += (AUTO_WAIT_STATE === 1'b1);
            cs |= (CORE_RESET === 1'b1);
            sl |= (DRAM_REFRESH_STROBE_N === 1'b0);
            @(posedge CLK_SYS);
        end
    endtask

    task automatic bound();
        INSTR_END <= 1'b1;
        cyc(1);
        INSTR_END <= 1'b0;
        obs(8);
    endtask

    task automatic en_irq();
        IRQ_ENABLE_INSTRUCTION <= 1'b1;
        cyc(1);
        IRQ_ENABLE_INSTRUCTION <= 1'b0;
        #1;
        chk(IRQ_ENABLED, 0);
        cyc(1);
        bound();
        chk(ni, 0);
        #1;
        chk(IRQ_ENABLED, 1);
        cyc(1);
    endtask

    task automatic irq(input logic [1:0] m, input logic [25:0] e);
        IM_VALUE <= m;
        IM_SET <= 1'b1;
        cyc(1);
        IM_SET <= 1'b0;
        p_int <= 1'b1;
        cyc(5);
        en_irq();
        expq.push_back(e);
        bound();
        p_int <= 1'b0;
        chk(ni, 5);
        chk(nw, 2);
        #1;
        chk(INT_MODE, m);
        chk(IRQ_ENABLED, 0);
        cyc(1);
    endtask

    // every service pulse retires the oldest expectation
    always @(posedge CLK_SYS) begin
        if (SERVICE_VALID === 1'b1) begin
            if (expq.size() == 0)
                chk_svc(SERVICE_ADDR, 26'h3FFFFFF);
            else chk_svc({SERVICE_ADDR, PUSH_PC, SERVICE_OPCODE_VALID,
                SERVICE_OPCODE}, expq.pop_front());
        end
    end

    // a full run is well under 2000 cycles
    initial begin
        cyc(20000);
        error_cnt++;
        results();
    end

    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'hB889253E));
        cyc(16);
        RST_N <= 1'b1;
        cyc(3);
        #1;
        chk(VECTOR_PAGE, 0);
        chk(REFRESH_ADDR, 0);
        chk(IRQ_ENABLED, 0);
        chk(INT_MODE, 0);
        chk(BUS_HOLD_GRANT_N, 1);
        cyc(1);
        // refresh wraps its low seven bits
        LOAD_DATA <= 8'hFF;
        REFRESH_LOAD <= 1'b1;
        cyc(1);
        REFRESH_LOAD <= 1'b0;
        REFRESH_SLOT <= 1'b1;
        cyc(1);
        REFRESH_SLOT <= 1'b0;
        obs(3);
        chk(sl, 1);
        #1;
        chk(REFRESH_ADDR, 16'h0080);
        cyc(1);
        // the three maskable modes, mode 2 out of halt
        a = 8'($urandom);
        p_ack <= a;
        irq(CRI_IM0, {16'h0000, 1'b0, 1'b1, a});
        irq(CRI_IM1, {16'h0038, 1'b1, 1'b0, 8'h00});
        a = 8'($urandom);
        pg = 8'($urandom);
        p_ack <= a;
        LOAD_DATA <= pg;
        VECTOR_PAGE_LOAD <= 1'b1;
        HALT_ENTER <= 1'b1;
        cyc(1);
        VECTOR_PAGE_LOAD <= 1'b0;
        HALT_ENTER <= 1'b0;
        #1;
        chk(HALT_N, 0);
        cyc(1);
        irq(CRI_IM2, {pg, a[7:1], 1'b0, 1'b1, 1'b0, 8'h00});
        #1;
        chk(HALT_N, 1);
        cyc(1);
        // non-maskable entry while disabled
        p_nmi <= 1'b1;
        cyc(5);
        expq.push_back({16'h0066, 1'b1, 1'b0, 8'h00});
        bound();
        chk(ni, 0);
        p_nmi <= 1'b0;
        // bus held away: no refresh, no interrupt, then retried
        en_irq();
        p_hold <= 1'b1;
        cyc(5);
        M_CYCLE_END <= 1'b1;
        cyc(1);
        M_CYCLE_END <= 1'b0;
        obs(2);
        #1;
        chk(BUS_HOLD_GRANT_N, 0);
        chk({ADDR_OE, DATA_OE, CTRL_OE}, 0);
        cyc(1);
        REFRESH_SLOT <= 1'b1;
        p_int <= 1'b1;
        cyc(1);
        REFRESH_SLOT <= 1'b0;
        obs(6);
        chk(sl, 0);
        bound();
        chk(ni, 0);
        p_hold <= 1'b0;
        cyc(5);
        #1;
        chk({BUS_HOLD_GRANT_N, ADDR_OE, DATA_OE, CTRL_OE}, 15);
        cyc(1);
        expq.push_back({pg, a[7:1], 1'b0, 1'b1, 1'b0, 8'h00});
        bound();
        chk(ni, 5);
        p_int <= 1'b0;
        // nmi return restores the saved enable, disable clears it
        en_irq();
        p_nmi <= 1'b1;
        cyc(5);
        expq.push_back({16'h0066, 1'b1, 1'b0, 8'h00});
        bound();
        p_nmi <= 1'b0;
        #1;
        chk(IRQ_ENABLED, 0);
        cyc(1);
        IRQ_RETURN_NMI <= 1'b1;
        cyc(1);
        IRQ_RETURN_NMI <= 1'b0;
        #1;
        chk(IRQ_ENABLED, 1);
        cyc(1);
        IRQ_DISABLE_INSTRUCTION <= 1'b1;
        cyc(1);
        IRQ_DISABLE_INSTRUCTION <= 1'b0;
        #1;
        chk(IRQ_ENABLED, 0);
        cyc(1);
        // reset pin: two clocks ignored, three clocks valid
        en_irq();
        RESET_PIN_N <= 1'b0;
        cyc(2);
        RESET_PIN_N <= 1'b1;
        obs(10);
        chk(cs, 0);
        RESET_PIN_N <= 1'b0;
        cyc(3);
        RESET_PIN_N <= 1'b1;
        obs(10);
        chk(cs, 1);
        #1;
        chk(CORE_RESET, 0);
        chk(VECTOR_PAGE, 0);
        chk(REFRESH_ADDR, 0);
        chk(IRQ_ENABLED, 0);
        chk(INT_MODE, 0);
        chk(expq.size(), 0);
        results();
    end
endmodule

`default_nettype wire
